// [rtl/tlb_flush_mirror.sv]
// What this block does
// - group-set index: group low, address bits above
// - tag word bit 0 is entry valid
// - control field switches group-set addressing
// - flush write clears all, or one group in group-set mode
// - store_invalid_entry decides storing invalid entries while CTRL_XLATE is set; with it clear they are always stored
// - no transfer forwarded during a flush
// - byte parity on both caches, checked per read
// - parity error handled as miss, refetched
// - parity errors in status and statistics
// - data and tag error injection registers
// - one-cycle found and absent pulses
// - one-cycle bypass, granted, denied pulses
// - table_fetch_active high during memory fetch
// - search_active high during lookup or walk
// - parity_fault pulse on protection cache error
// - register page mirrored every 0x1000
// - four mirrored blocks with write protection
// - per-block access-control register selects writes
// - mirrors never write control or diagnostic registers
// - those registers exist only in primary page
// - plain index: address bits, group in tag
//
// Purpose: direct-mapped translation cache with flush, parity, statistics and mirrored APB registers
// Assumes: one clock pclk at 200 MHz, presetn asynchronous active low, zero-wait APB slave
// Notes: the protection vector cache lives outside; only its parity check and its error injection registers are here
`timescale 1ns/100ps
module tlb_flush_mirror
  import tlb_pkg::*;
#(
  parameter int SETS = 32
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lk_valid,
  output logic lk_ready,
  input wire lookup_req_s lk_req,
  output logic rsp_valid,
  output logic [31:0] rsp_addr,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic fetch_ack,
  input wire logic [127:0] fetch_data,
  input wire logic apv_rd_valid,
  input wire logic [127:0] apv_rd_data,
  input wire logic [15:0] apv_rd_par,
  output logic [31:0] apv_inj_data,
  output logic [31:0] apv_inj_tag,
  output logic xfer_hold,
  output logic lookup_found,
  output logic lookup_absent,
  output logic bypass,
  output logic access_granted,
  output logic access_denied,
  output logic table_fetch_active,
  output logic search_active,
  output logic parity_fault
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tlb_state_e state_q, state_d;
  logic [31:0] ctrl_q, status_q, inj_data_q, inj_tag_q;
  logic [31:0] group_q [NUM_GROUPS];
  logic [31:0] acc_q [1:4];
  logic flush_pend_q, flush_all_q;
  logic [2:0] flush_gid_q;
  logic [4:0] flush_idx_q;
  lookup_req_s req_q;
  logic [SETS-1:0] valid_q;
  logic [127:0] data_mem [SETS];
  logic [15:0] dpar_mem [SETS];
  logic [15:0] tag_mem [SETS];
  logic [2:0] tpar_mem [SETS];
  logic found_q, absent_q, bypass_q, grant_q, deny_q, pfault_q, rsp_q;
  logic [31:0] rsp_addr_q;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire [2:0] blk = paddr[14:12];
  wire [11:0] off = paddr[11:0];
  wire primary = (blk == 3'h0) && (paddr[31:15] == 17'h0);
  wire mirror = (blk != 3'h0) && (blk <= NUM_MIRRORS) && (paddr[31:15] == 17'h0);
  wire page_ok = primary || mirror;
  wire hit_ctrl = off == OFF_CTRL;
  wire hit_flush = off == OFF_FLUSH;
  wire hit_status = off == OFF_STATUS;
  wire hit_group = (off[11:5] == OFF_GROUP0[11:5]) && (off[1:0] == 2'h0);
  wire [2:0] gsel = off[4:2];
  wire hit_inj_d = off == OFF_INJ_DATA;
  wire hit_inj_t = off == OFF_INJ_TAG;
  wire hit_acc_real = (off == OFF_ACC0 + 12'h004) || (off == OFF_ACC0 + 12'h008)
                   || (off == OFF_ACC0 + 12'h00c) || (off == OFF_ACC0 + 12'h010)
                   || (off == OFF_ACC0);
  wire [2:0] asel = (off == OFF_ACC0 + 12'h010) ? 3'h4 : {1'b0, off[3:2]};
  wire hit_prim_only = hit_ctrl || hit_inj_d || hit_inj_t || hit_acc_real;
  wire hit_any = hit_ctrl || hit_flush || hit_status || hit_group || hit_inj_d || hit_inj_t || hit_acc_real;
  wire access = psel && penable;
  wire wr = access && pwrite && page_ok;
  wire [31:0] perm = mirror ? acc_q[blk] : 32'hffff_ffff;
  // mirrors may touch only flush, status and group control, each gated by its own bit
  wire wr_ctrl = wr && primary && hit_ctrl;
  wire wr_inj_d = wr && primary && hit_inj_d;
  wire wr_inj_t = wr && primary && hit_inj_t;
  wire wr_acc = wr && primary && hit_acc_real && (asel != 3'h0);
  wire wr_flush = wr && hit_flush && perm[ACC_FLUSH];
  wire wr_status = wr && hit_status && perm[ACC_STATUS];
  wire wr_group = wr && hit_group && perm[ACC_GRP_LSB + gsel];
  wire [31:0] rd_acc = (asel == 3'h0) ? RST_WORD : acc_q[asel];
  wire [31:0] rd_word = hit_ctrl ? ctrl_q
                      : hit_flush ? {29'h0, status_q[ST_BUSY], 2'h0}
                      : hit_status ? status_q
                      : hit_group ? group_q[gsel]
                      : hit_inj_d ? inj_data_q
                      : hit_inj_t ? inj_tag_q
                      : hit_acc_real ? rd_acc : RST_WORD;
  wire rd_ok = page_ok && hit_any && !(mirror && hit_prim_only);
  assign pready = 1'b1;
  assign pslverr = access && !(page_ok && hit_any);
  assign prdata = (access && !pwrite && rd_ok) ? rd_word : RST_WORD;

  // ---------------------------------------------------------------
  // cache indexing and checking
  // ---------------------------------------------------------------
  wire gs_on = ctrl_q[CTRL_GS];
  wire [4:0] set_gs = {req_q.addr[SET_LSB +: 2], req_q.group};
  wire [4:0] set_plain = req_q.addr[SET_LSB +: 5];
  wire [4:0] set_idx = gs_on ? set_gs : set_plain;
  wire [15:0] tag_gs = req_q.addr[31:16];
  wire [15:0] tag_plain = {req_q.group, req_q.addr[31:19]};
  wire [15:0] tag_now = gs_on ? tag_gs : tag_plain;
  tag_word_s tw_rd;
  assign tw_rd = '{tag: tag_mem[set_idx], valid: valid_q[set_idx]};
  wire [127:0] line_rd = data_mem[set_idx];
  wire perr_tlb = tw_rd.valid && ((par_tag(tw_rd) != tpar_mem[set_idx])
                  || (par_line(line_rd) != dpar_mem[set_idx]));
  wire tag_match = tw_rd.valid && (tw_rd.tag == tag_now) && !perr_tlb;
  wire perr_apv = apv_rd_valid && (par_line(apv_rd_data) != apv_rd_par);
  wire [127:0] line_use = (state_q == S_FETCH) ? fetch_data : line_rd;
  wire [31:0] pte = line_use[req_q.addr[13:12]*32 +: 32];
  wire allow = pte[PTE_V] && (pte[PTE_W] || !req_q.write);
  wire fill_done = (state_q == S_FETCH) && fetch_ack;
  wire store_ok = pte[PTE_V] || ctrl_q[CTRL_SIV] || !ctrl_q[CTRL_XLATE];
  wire do_fill = fill_done && store_ok;
  wire flush_hit = flush_all_q || (flush_idx_q[2:0] == flush_gid_q);
  wire check_hit = (state_q == S_CHECK) && tag_match;
  wire check_miss = (state_q == S_CHECK) && !tag_match;
  wire take = lk_valid && lk_ready;
  tag_word_s tw_wr;
  assign tw_wr = '{tag: tag_now, valid: 1'b1};

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  assign lk_ready = (state_q == S_IDLE) && !flush_pend_q;
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:
        if (flush_pend_q)
          state_d = S_FLUSH;
        else if (take && !lk_req.pass)
          state_d = S_CHECK;
      S_CHECK:
        state_d = tag_match ? S_IDLE : S_FETCH;
      S_FETCH:
        if (fetch_ack)
          state_d = S_IDLE;
      S_FLUSH:
        if (flush_idx_q == LAST_SET)
          state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= S_IDLE;
      req_q <= '0;
      flush_idx_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (take)
        req_q <= lk_req;
      flush_idx_q <= (state_q == S_FLUSH) ? flush_idx_q + 5'h01 : 5'h00;
    end
  end

  // valid bits reset and flush; contents arrays need no reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      valid_q <= '0;
    else if ((state_q == S_FLUSH) && flush_hit)
      valid_q[flush_idx_q] <= 1'b0;
    else if (do_fill)
      valid_q[set_idx] <= 1'b1;
  end

  always_ff @(posedge pclk)
  begin
    if (do_fill)
    begin
      data_mem[set_idx] <= fetch_data;
      tag_mem[set_idx] <= tag_now;
      dpar_mem[set_idx] <= par_line(fetch_data) ^ (inj_data_q[INJ_ARM] ? inj_data_q[15:0] : 16'h0000);
      tpar_mem[set_idx] <= par_tag(tw_wr) ^ (inj_tag_q[INJ_ARM] ? inj_tag_q[2:0] : 3'h0);
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= RST_WORD;
      inj_data_q <= RST_WORD;
      inj_tag_q <= RST_WORD;
      for (int i = 0; i < NUM_GROUPS; i++)
        group_q[i] <= RST_WORD;
      for (int i = 1; i <= 4; i++)
        acc_q[i] <= RST_WORD;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= {29'h0, pwdata[2:0]};
      // an armed injection is consumed by the next fill
      if (wr_inj_d)
        inj_data_q <= pwdata;
      else if (do_fill)
        inj_data_q[INJ_ARM] <= 1'b0;
      if (wr_inj_t)
        inj_tag_q <= pwdata;
      else if (do_fill)
        inj_tag_q[INJ_ARM] <= 1'b0;
      if (wr_group)
        group_q[gsel] <= pwdata;
      if (wr_acc)
        acc_q[asel] <= pwdata;
    end
  end

  // flush request waits for an in-flight lookup to finish, hold is raised at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flush_pend_q <= 1'b0;
      flush_all_q <= 1'b0;
      flush_gid_q <= 3'h0;
    end
    else if (wr_flush && (pwdata[FL_ALL] || pwdata[FL_GRP]))
    begin
      flush_pend_q <= 1'b1;
      flush_all_q <= pwdata[FL_ALL];
      flush_gid_q <= pwdata[FL_GID_LSB +: 3];
    end
    else if ((state_q == S_FLUSH) && (flush_idx_q == LAST_SET))
      flush_pend_q <= 1'b0;
  end

  // sticky error bits: write one to clear, a new error in the same cycle wins
  wire set_tlb_perr = check_miss && perr_tlb;
  wire clr_tlb_perr = wr_status && pwdata[ST_TLB_PERR];
  wire clr_apv_perr = wr_status && pwdata[ST_APV_PERR];
  // busy follows the pending flag's next value, so the hold drops when lookups are taken again
  wire flush_start = wr_flush && (pwdata[FL_ALL] || pwdata[FL_GRP]);
  wire flush_last = (state_q == S_FLUSH) && (flush_idx_q == LAST_SET);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= RST_WORD;
    else
    begin
      status_q[ST_TLB_PERR] <= set_tlb_perr || (status_q[ST_TLB_PERR] && !clr_tlb_perr);
      status_q[ST_APV_PERR] <= perr_apv || (status_q[ST_APV_PERR] && !clr_apv_perr);
      status_q[ST_BUSY] <= flush_start || (flush_pend_q && !flush_last);
    end
  end

  // ---------------------------------------------------------------
  // statistics and response
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      found_q <= 1'b0;
      absent_q <= 1'b0;
      bypass_q <= 1'b0;
      grant_q <= 1'b0;
      deny_q <= 1'b0;
      pfault_q <= 1'b0;
      rsp_q <= 1'b0;
      rsp_addr_q <= RST_WORD;
    end
    else
    begin
      found_q <= check_hit;
      absent_q <= check_miss;
      bypass_q <= take && lk_req.pass;
      grant_q <= (check_hit || fill_done) && allow;
      deny_q <= (check_hit || fill_done) && !allow;
      pfault_q <= perr_apv;
      rsp_q <= check_hit || fill_done || (take && lk_req.pass);
      if (take && lk_req.pass)
        rsp_addr_q <= lk_req.addr;
      else if (check_hit || fill_done)
        rsp_addr_q <= {pte[27:8], req_q.addr[11:0]};
    end
  end

  assign lookup_found = found_q;
  assign lookup_absent = absent_q;
  assign bypass = bypass_q;
  assign access_granted = grant_q;
  assign access_denied = deny_q;
  assign parity_fault = pfault_q;
  assign rsp_valid = rsp_q;
  assign rsp_addr = rsp_addr_q;
  assign xfer_hold = status_q[ST_BUSY];
  assign fetch_req = state_q == S_FETCH;
  assign fetch_addr = req_q.addr;
  assign table_fetch_active = state_q == S_FETCH;
  assign search_active = (state_q == S_CHECK) || (state_q == S_FETCH);
  assign apv_inj_data = inj_data_q;
  assign apv_inj_tag = inj_tag_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_found_one_cycle: assert property (lookup_found |=> !lookup_found) else $error("found pulse too long");
  a_absent_cause: assert property (check_miss |=> lookup_absent ##1 !lookup_absent)
    else $error("absent pulse wrong");
  a_miss_fetches: assert property (check_miss |=> table_fetch_active && search_active)
    else $error("miss did not start fetch");
  a_hold_flush: assert property ((state_q == S_FLUSH) |-> !lk_ready && xfer_hold)
    else $error("transfer accepted during flush");
  a_flush_length: assert property ($rose(state_q == S_FLUSH) |-> (state_q == S_FLUSH) [*8] ##25 (state_q == S_IDLE))
    else $error("flush did not take 32 cycles");
  a_flush_all_clears: assert property ((state_q == S_FLUSH && flush_all_q && flush_idx_q == LAST_SET) |=> valid_q == '0)
    else $error("full flush left valid entries");
  a_mirror_ctrl: assert property ((wr && mirror && hit_ctrl) |=> $stable(ctrl_q))
    else $error("mirror wrote control");
  a_perr_status: assert property (set_tlb_perr |=> status_q[ST_TLB_PERR] && lookup_absent)
    else $error("parity error not recorded");
  a_apv_fault: assert property (perr_apv |=> parity_fault && status_q[ST_APV_PERR])
    else $error("protection parity not flagged");
  a_grant_excl: assert property (!(access_granted && access_denied)) else $error("grant and deny together");
  a_gs_index: assert property ((state_q == S_CHECK && gs_on) |-> set_idx[2:0] == req_q.group)
    else $error("group not in set index");
  a_denied_write: assert property ((wr && mirror && hit_group && !perm[ACC_GRP_LSB + gsel]) |=> $stable(group_q[gsel]))
    else $error("protected group register written");

  c_hit: cover property (lookup_found);
  c_fill_grant: cover property (fill_done && allow);
  c_group_flush: cover property (state_q == S_FLUSH && !flush_all_q);
  c_mirror_write: cover property (wr_group && mirror);
endmodule

// [shared/tlb_pkg.sv]
// Purpose: shared constants, types and parity helpers for the translation cache block
// Assumes: 32-bit APB, byte addresses as printed
// Notes: none
package tlb_pkg;
  // ---------------------------------------------------------------
  // register map (byte offsets inside one 4 KiB page)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h010;
  localparam logic [11:0] OFF_FLUSH = 12'h014;
  localparam logic [11:0] OFF_STATUS = 12'h018;
  localparam logic [11:0] OFF_GROUP0 = 12'h080;
  localparam logic [11:0] OFF_INJ_DATA = 12'h0e8;
  localparam logic [11:0] OFF_INJ_TAG = 12'h0ec;
  localparam logic [11:0] OFF_ACC0 = 12'h100;
  localparam logic [2:0] NUM_MIRRORS = 3'h4;
  localparam int NUM_GROUPS = 8;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_XLATE = 0;
  localparam int CTRL_SIV = 1;
  localparam int CTRL_GS = 2;
  localparam int FL_ALL = 0;
  localparam int FL_GRP = 1;
  localparam int FL_GID_LSB = 4;
  localparam int ST_TLB_PERR = 0;
  localparam int ST_APV_PERR = 1;
  localparam int ST_BUSY = 2;
  localparam int ACC_FLUSH = 0;
  localparam int ACC_STATUS = 1;
  localparam int ACC_GRP_LSB = 2;
  localparam int INJ_ARM = 31;
  localparam int SET_LSB = 14;
  localparam int PTE_V = 1;
  localparam int PTE_W = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [4:0] LAST_SET = 5'h1f;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pass;
    logic write;
    logic [2:0] group;
    logic [31:0] addr;
  } lookup_req_s;
  typedef struct packed {
    logic [15:0] tag;
    logic valid;
  } tag_word_s;
  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_FETCH, S_FLUSH} tlb_state_e;

  function automatic logic [15:0] par_line(input logic [127:0] d);
    logic [15:0] p;
    p = '0;
    for (int i = 0; i < 16; i++)
    begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction

  function automatic logic [2:0] par_tag(input tag_word_s t);
    logic [23:0] w;
    w = {7'h00, t};
    return {^w[23:16], ^w[15:8], ^w[7:0]};
  endfunction
endpackage

// [tb/pte_memory_model.sv]
// Purpose: memory side that answers page table line fetches
// Assumes: one fetch outstanding, single-cycle acknowledge
// Notes: data lines toggle outside the acknowledge cycle so stale data never looks valid
`timescale 1ns/100ps
module pte_memory_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fetch_req,
  input wire logic [19:0] page_base,
  input wire logic slow,
  input wire logic pte_valid,
  output logic fetch_ack,
  output logic [127:0] fetch_data
);
  logic [3:0] wait_q;
  // four entries per line, writable, valid bit as commanded
  function automatic logic [127:0] line(input logic [19:0] b, input logic v);
    logic [127:0] l;
    for (int i = 0; i < 4; i++)
    begin
      l[i*32 +: 32] = {4'h0, b + 20'(i), 5'h00, 1'b1, v, 1'b0};
    end
    return l;
  endfunction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_q <= 4'h0;
      fetch_ack <= 1'b0;
      fetch_data <= {8{16'ha5c3}};
    end
    else if (fetch_req && !fetch_ack && wait_q >= (slow ? 4'h6 : 4'h0))
    begin
      fetch_ack <= 1'b1;
      fetch_data <= line(page_base, pte_valid);
      wait_q <= 4'h0;
    end
    else
    begin
      fetch_ack <= 1'b0;
      fetch_data <= ~fetch_data;
      wait_q <= fetch_req ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

// [tb/iommu_tlb_flush_parity_mirror_tb.sv]
// Purpose: self-checking bench for the translation cache block
// Assumes: zero-wait APB slave, one lookup at a time
// Notes: stat pulses are counted by a monitor and compared as deltas
`timescale 1ns/100ps
module iommu_tlb_flush_parity_mirror_tb;
  import tlb_pkg::*;
  localparam logic [31:0] ADDR = 32'h0004_5678;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [31:0] paddr, pwdata, prdata, rd, rsp_addr, fetch_addr, apv_inj_data, apv_inj_tag;
  logic lk_valid, lk_ready, rsp_valid, fetch_req, fetch_ack, apv_rd_valid, xfer_hold;
  logic lookup_found, lookup_absent, bypass, access_granted, access_denied;
  logic table_fetch_active, search_active, parity_fault, slow, pv;
  lookup_req_s lk_req;
  logic [127:0] fetch_data, apv_rd_data;
  logic [15:0] apv_rd_par;
  logic [19:0] base;
  logic [4:0] stat;
  int cnt [5];
  int cyc, n_perr, n_bad, n_errors, comparisons;

  tlb_flush_mirror #(.SETS(32)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lk_valid(lk_valid), .lk_ready(lk_ready), .lk_req(lk_req), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .apv_rd_valid(apv_rd_valid), .apv_rd_data(apv_rd_data), .apv_rd_par(apv_rd_par),
    .apv_inj_data(apv_inj_data), .apv_inj_tag(apv_inj_tag), .xfer_hold(xfer_hold),
    .lookup_found(lookup_found), .lookup_absent(lookup_absent), .bypass(bypass),
    .access_granted(access_granted), .access_denied(access_denied),
    .table_fetch_active(table_fetch_active), .search_active(search_active), .parity_fault(parity_fault));
  pte_memory_model u_mem (.pclk(pclk), .presetn(presetn), .fetch_req(fetch_req), .page_base(base),
    .slow(slow), .pte_valid(pv), .fetch_ack(fetch_ack), .fetch_data(fetch_data));

  // ------------------------------------------------------------
  // monitor and helpers
  // ------------------------------------------------------------
  assign stat = {lookup_found, lookup_absent, bypass, access_granted, access_denied};
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    for (int i = 0; i < 5; i++)
      if (stat[i] === 1'b1)
        cnt[i]++;
    if (parity_fault === 1'b1)
      n_perr++;
    if ((fetch_req === 1'b1 && table_fetch_active !== 1'b1) || (xfer_hold === 1'b1 && lk_ready !== 1'b0)
        || (lookup_absent === 1'b1 && search_active !== 1'b1)
        || (fetch_req === 1'b1 && fetch_addr !== ADDR))
      n_bad++;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] at(input logic [2:0] n, input logic [11:0] off);
    return {17'h0, n, off};
  endfunction
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    check("write pslverr", err, 0);
  endtask
  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask
  task automatic flush(input logic [31:0] d);
    wr(at(3'h0, OFF_FLUSH), d);
    @(posedge pclk);
    check("xfer_hold", xfer_hold, 1);
    while (xfer_hold !== 1'b0)
      @(posedge pclk);
  endtask
  // exp order: found, absent, bypass, granted, denied
  task automatic lk(input logic p, input logic [2:0] g, input logic [4:0] exp, input logic ca);
    int c0 [5];
    c0 = cnt;
    @(posedge pclk);
    lk_valid <= 1'b1;
    lk_req <= {p, 1'b0, g, ADDR};
    do
      @(posedge pclk);
    while (lk_ready !== 1'b1);
    lk_valid <= 1'b0;
    do
      @(posedge pclk);
    while (rsp_valid !== 1'b1);
    if (ca)
      check("rsp_addr", rsp_addr, p ? ADDR : {base + 20'(ADDR[13:12]), ADDR[11:0]});
    @(posedge pclk);
    for (int i = 0; i < 5; i++)
      check("stat pulses", cnt[i] - c0[i], 32'(exp[i]));
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, lk_valid, apv_rd_valid, slow} = '0;
    {paddr, pwdata, lk_req, apv_rd_data, apv_rd_par} = '0;
    base = 20'h12340;
    pv = 1'b1;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl reset", at(3'h0, OFF_CTRL), RST_WORD);
    rdchk("status reset", at(3'h0, OFF_STATUS), RST_WORD);
    wr(at(3'h0, OFF_CTRL), 32'h0000_0001);
    wr(at(3'h0, OFF_ACC0 + 12'h004), 32'h0000_0004);
    wr(at(3'h1, OFF_CTRL), 32'h0000_0007);
    rdchk("ctrl", at(3'h0, OFF_CTRL), 32'h0000_0001);
    rdchk("mirror ctrl", at(3'h1, OFF_CTRL), 32'h0000_0000);
    wr(at(3'h1, OFF_GROUP0), 32'h0000_00a1);
    wr(at(3'h1, OFF_GROUP0 + 12'h004), 32'h0000_00b1);
    wr(at(3'h2, OFF_GROUP0), 32'h0000_00c1);
    rdchk("group 0", at(3'h4, OFF_GROUP0), 32'h0000_00a1);
    rdchk("group 1", at(3'h0, OFF_GROUP0 + 12'h004), 32'h0000_0000);
    apb(1'b0, at(3'h5, OFF_CTRL), 32'h0000_0000);
    check("block 5 pslverr", err, 1);
    lk(1'b1, 3'h0, 5'b00100, 1'b1);
    slow <= 1'b1;
    lk(1'b0, 3'h0, 5'b01010, 1'b1);
    slow <= 1'b0;
    lk(1'b0, 3'h0, 5'b10010, 1'b1);
    lk(1'b0, 3'h1, 5'b01010, 1'b1);
    lk(1'b0, 3'h0, 5'b01010, 1'b1);
    wr(at(3'h0, OFF_CTRL), 32'h0000_0005);
    base = 20'h54320;
    flush(32'h0000_0001);
    lk(1'b0, 3'h0, 5'b01010, 1'b1);
    lk(1'b0, 3'h1, 5'b01010, 1'b1);
    lk(1'b0, 3'h0, 5'b10010, 1'b1);
    flush(32'h0000_0012);
    lk(1'b0, 3'h0, 5'b10010, 1'b1);
    lk(1'b0, 3'h1, 5'b01010, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      wr(at(3'h0, k ? OFF_INJ_TAG : OFF_INJ_DATA), 32'h8000_0001);
      @(posedge pclk);
      check("inj echo", k ? apv_inj_tag : apv_inj_data, 32'h8000_0001);
      flush(32'h0000_0001);
      lk(1'b0, 3'h0, 5'b01010, 1'b1);
      lk(1'b0, 3'h0, 5'b01010, 1'b1);
      rdchk("status tlb perr", at(3'h0, OFF_STATUS), 32'h0000_0001);
      wr(at(3'h0, OFF_STATUS), 32'h0000_0001);
      lk(1'b0, 3'h0, 5'b10010, 1'b1);
    end
    // every byte odd, byte 0 parity wrong in the first beat only
    @(posedge pclk);
    apv_rd_valid <= 1'b1;
    apv_rd_data <= {16{8'h01}};
    apv_rd_par <= 16'hfffe;
    @(posedge pclk);
    apv_rd_par <= 16'hffff;
    @(posedge pclk);
    apv_rd_valid <= 1'b0;
    apv_rd_data <= ~apv_rd_data;
    repeat (3) @(posedge pclk);
    check("apv fault pulses", n_perr, 1);
    rdchk("status apv perr", at(3'h0, OFF_STATUS), 32'h0000_0002);
    pv = 1'b0;
    flush(32'h0000_0001);
    lk(1'b0, 3'h0, 5'b01001, 1'b0);
    lk(1'b0, 3'h0, 5'b01001, 1'b0);
    wr(at(3'h0, OFF_CTRL), 32'h0000_0007);
    lk(1'b0, 3'h0, 5'b01001, 1'b0);
    lk(1'b0, 3'h0, 5'b10001, 1'b0);
    check("monitor faults", n_bad, 0);
    print_verdict();
  end
endmodule
